// ===== bench/match_capture_timer_bench.sv
// Purpose: self-checking bench of the match/capture timer
// Assumes: Avalon-MM master tasks, pin model drives capture and count pins
// Notes:   byteenable and clk_en held active throughout
`timescale 1ns/1ps
module match_capture_timer_bench;
  logic        clk_sys;
  logic        reset_n;
  logic        clk_en;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        count_in;
  logic        cap_in0;
  logic        cap_in1;
  logic [3:0]  match_out;
  logic        dma_req0;
  logic        dma_req1;
  logic        irq;
  logic [31:0] rd;
  logic        prev_out;
  int          k;
  int          n_fail;
  int          n_tests;

  mct_timer DUT (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .clk_en             (clk_en),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (avs_byteenable),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .count_in           (count_in),
    .timer0_capture_in0 (cap_in0),
    .timer0_capture_in1 (cap_in1),
    .timer0_match_out0  (match_out[0]),
    .timer0_match_out1  (match_out[1]),
    .timer0_match_out2  (match_out[2]),
    .timer0_match_out3  (match_out[3]),
    .dma_req0           (dma_req0),
    .dma_req1           (dma_req1),
    .irq                (irq)
  );

  mct_pins_model pins (
    .clk_sys  (clk_sys),
    .cap_in0  (cap_in0),
    .cap_in1  (cap_in1),
    .count_in (count_in)
  );

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= addr;
    avs_writedata <= data;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      n++;
      @(posedge clk_sys);
    end
    if (n == 100) begin
      n_fail++;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    bus(1'b1, addr, data);
  endtask

  task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp, input string what);
    bus(1'b0, addr, 32'h0);
    check(rd, exp, what);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    end_of_test;
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    n_fail         = 0;
    n_tests        = 0;
    reset_n        = 1'b0;
    clk_en         = 1'b1;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    check({25'h0, irq, dma_req1, dma_req0, match_out}, 32'h0, "pins after reset");
    rdchk(mct_pkg::OFF_CTRL, 32'h0, "ctrl reset");
    rdchk(mct_pkg::OFF_COUNT, 32'h0, "count reset");
    rdchk(mct_pkg::OFF_STATUS, 32'h0, "status reset");
    wr(8'h40, 32'hffffffff);
    rdchk(8'h40, 32'h0, "unmapped read");
    rdchk(mct_pkg::OFF_CLEAR, 32'h0, "clear reads zero");
    // external count source, divide by two
    wr(mct_pkg::OFF_PRE_TERM, 32'h1);
    wr(mct_pkg::OFF_CTRL, 32'h2);
    wr(mct_pkg::OFF_CTRL, 32'h5);
    pins.pulse_count(6);
    rdchk(mct_pkg::OFF_COUNT, 32'h3, "count after six edges");
    rdchk(mct_pkg::OFF_PRE_CNT, 32'h0, "prescale at terminal wrap");
    pins.pulse_count(1);
    rdchk(mct_pkg::OFF_PRE_CNT, 32'h1, "prescale step");
    rdchk(mct_pkg::OFF_COUNT, 32'h3, "count waits for terminal");
    // capture channels with the count frozen at 3
    wr(mct_pkg::OFF_CAP_CTRL, 32'h15);
    wr(mct_pkg::OFF_IRQ_EN, 32'h10);
    pins.set_cap(0, 1'b1);
    rdchk(mct_pkg::OFF_CAP0, 32'h3, "capture 0 on rise");
    rdchk(mct_pkg::OFF_STATUS, 32'h10, "capture 0 flag");
    check({31'h0, irq}, 32'h1, "irq on capture");
    pins.set_cap(1, 1'b1);
    rdchk(mct_pkg::OFF_CAP1, 32'h0, "capture 1 ignores rise");
    pins.set_cap(1, 1'b0);
    rdchk(mct_pkg::OFF_CAP1, 32'h3, "capture 1 on fall");
    rdchk(mct_pkg::OFF_STATUS, 32'h10, "capture 1 flag disabled");
    wr(mct_pkg::OFF_IRQ_EN, 32'h0);
    settle;
    check({31'h0, irq}, 32'h0, "irq masked");
    rdchk(mct_pkg::OFF_STATUS, 32'h10, "flag sticky");
    wr(mct_pkg::OFF_CLEAR, 32'h10);
    wr(mct_pkg::OFF_IRQ_EN, 32'h10);
    settle;
    check({31'h0, irq}, 32'h0, "irq after clear");
    rdchk(mct_pkg::OFF_STATUS, 32'h0, "flag cleared");
    // stop on match 0, every output action once per pass
    wr(mct_pkg::OFF_PRE_TERM, 32'h0);
    wr(mct_pkg::OFF_MATCH_CTRL, 32'h24d);
    for (int m = 0; m < 4; m++) begin
      wr(mct_pkg::OFF_MATCH_BASE + 8'(4 * m), 32'h2);
    end
    for (int p = 0; p < 2; p++) begin
      wr(mct_pkg::OFF_CTRL, 32'h2);
      wr(mct_pkg::OFF_CLEAR, 32'h3f);
      wr(mct_pkg::OFF_EXT_CTRL, (p == 0) ? 32'he4 : 32'h1b);
      wr(mct_pkg::OFF_CTRL, 32'h1);
      rd = 32'h1;
      k  = 0;
      while (rd[0] !== 1'b0 && k < 20) begin
        k++;
        bus(1'b0, mct_pkg::OFF_CTRL, 32'h0);
      end
      check(rd, 32'h0, "run cleared on stop");
      rdchk(mct_pkg::OFF_COUNT, 32'h2, "count held at match");
      rdchk(mct_pkg::OFF_STATUS, 32'hf, "match flags");
      check({28'h0, match_out}, (p == 0) ? 32'hc : 32'hb, "match outputs");
    end
    // reset on match 1 with toggle and dma, match 0 flags only
    wr(mct_pkg::OFF_CTRL, 32'h2);
    wr(mct_pkg::OFF_CLEAR, 32'h3f);
    wr(mct_pkg::OFF_MATCH_CTRL, 32'h011);
    wr(mct_pkg::OFF_MATCH_BASE + 8'h4, 32'h3);
    wr(mct_pkg::OFF_EXT_CTRL, 32'h20c);
    wr(mct_pkg::OFF_CTRL, 32'h1);
    k = 0;
    while (dma_req1 !== 1'b1 && k < 50) begin
      k++;
      @(posedge clk_sys);
    end
    prev_out = match_out[1];
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      check({31'h0, dma_req1}, (i == 3) ? 32'h1 : 32'h0, "dma period");
      check({31'h0, dma_req0}, 32'h0, "dma 0 disabled");
    end
    check({31'h0, match_out[1]}, {31'h0, ~prev_out}, "toggle per match");
    rdchk(mct_pkg::OFF_STATUS, 32'h1, "match 0 flag, counting on");
    end_of_test;
  end
endmodule

// ===== bench/mct_pins_model.sv
// Purpose: far side pins of the timer, capture inputs and count source
// Assumes: pins change by NBA right after a rising clk_sys
// Notes:   each count pulse is high one cycle, low one cycle
`timescale 1ns/1ps
module mct_pins_model (
  input  wire logic clk_sys,
  output logic      cap_in0,
  output logic      cap_in1,
  output logic      count_in
);
  initial begin
    cap_in0  = 1'b0;
    cap_in1  = 1'b0;
    count_in = 1'b0;
  end

  task automatic pulse_count(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      count_in <= 1'b1;
      @(posedge clk_sys);
      count_in <= 1'b0;
    end
  endtask

  // one extra edge so the timer has seen the new level
  task automatic set_cap(input int ch, input logic v);
    @(posedge clk_sys);
    if (ch == 0) begin
      cap_in0 <= v;
    end else begin
      cap_in1 <= v;
    end
    @(posedge clk_sys);
  endtask
endmodule

// ===== src/mct_capture.sv
// Purpose: one capture channel, snapshots the count on an input edge
// Assumes: capture input synchronous to clk_sys
// Notes:   event output is combinational, valid while clk_en is high
`timescale 1ns/1ps
module mct_capture #(
  parameter int W = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic         cap_in,
  input  wire logic         rise_en,
  input  wire logic         fall_en,
  input  wire logic [W-1:0] count,
  output logic      [W-1:0] cap_value,
  output logic              cap_event
);
  logic prev_reg;

  assign cap_event = clk_en & ((rise_en & cap_in & ~prev_reg) |
                               (fall_en & ~cap_in & prev_reg));

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prev_reg  <= 1'b0;
      cap_value <= '0;
    end else if (clk_en) begin
      prev_reg <= cap_in;
      if (cap_event) begin
        cap_value <= count;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_CAP_LOAD: assert property (cap_event |=> cap_value == $past(count))
    else $error("capture register missed the count");
  COV_CAP: cover property (cap_event);
endmodule

// ===== src/mct_pkg.sv
// Purpose: shared register map, field layout and reset values of the timer
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register
// Notes:   match word m sits at OFF_MATCH_BASE + 4*m
package mct_pkg;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int N_MATCH = 4;
  localparam int N_CAP   = 2;
  localparam int N_DMA   = 2;
  localparam int N_EV    = 6;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_COUNT      = 8'h04;
  localparam logic [7:0] OFF_PRE_TERM   = 8'h08;
  localparam logic [7:0] OFF_PRE_CNT    = 8'h0c;
  localparam logic [7:0] OFF_MATCH_BASE = 8'h10;
  localparam logic [7:0] OFF_MATCH_CTRL = 8'h20;
  localparam logic [7:0] OFF_EXT_CTRL   = 8'h24;
  localparam logic [7:0] OFF_CAP_CTRL   = 8'h28;
  localparam logic [7:0] OFF_CAP0       = 8'h2c;
  localparam logic [7:0] OFF_CAP1       = 8'h30;
  localparam logic [7:0] OFF_STATUS     = 8'h34;
  localparam logic [7:0] OFF_CLEAR      = 8'h38;
  localparam logic [7:0] OFF_IRQ_EN     = 8'h3c;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_HOLD    = 1;
  localparam int CTRL_EXT     = 2;
  localparam int MC_INT       = 0;
  localparam int MC_RST       = 1;
  localparam int MC_STOP      = 2;
  localparam int MC_STRIDE    = 3;
  localparam int EC_ACT_W     = 2;
  localparam int EC_DMA_POS   = 8;
  localparam int EC_STATE_POS = 16;
  localparam int CC_RISE      = 0;
  localparam int CC_FALL      = 1;
  localparam int CC_INT       = 2;
  localparam int CC_STRIDE    = 3;
  localparam int ST_CAP_POS   = 4;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [2:0]  RST_CTRL       = 3'h0;
  localparam logic [31:0] RST_WORD       = 32'h0;
  localparam logic [11:0] RST_MATCH_CTRL = 12'h000;
  localparam logic [7:0]  RST_ACT        = 8'h00;
  localparam logic [1:0]  RST_DMA_EN     = 2'h0;
  localparam logic [5:0]  RST_CAP_CTRL   = 6'h00;
  localparam logic [5:0]  RST_IRQ_EN     = 6'h00;
  localparam logic [5:0]  RST_STATUS     = 6'h00;
  localparam logic [3:0]  RST_OUT        = 4'h0;

  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_LOW,
    ACT_HIGH,
    ACT_TOGGLE
  } mct_act_type;
endpackage

// ===== src/mct_timer.sv
// Purpose: 32-bit match/capture timer with prescaler behind Avalon-MM
// Assumes: all inputs synchronous to clk_sys; clk_en low freezes all state
// Notes:   events latch in status; irq is a registered level
// Operation
// - count system clock or external input edges
// - 32-bit count through 32-bit prescaler
// - two channels capture count on input edge
// - capture may flag interrupt, per-channel enable
// - four match words, optional interrupt on equality
// - stop counting on selected match
// - reset count to zero on selected match
// - match drives output low, high, toggle, none
// - matches zero and one can request DMA
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module mct_timer (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        count_in,
  input  wire logic        timer0_capture_in0,
  input  wire logic        timer0_capture_in1,
  output logic             timer0_match_out0,
  output logic             timer0_match_out1,
  output logic             timer0_match_out2,
  output logic             timer0_match_out3,
  output logic             dma_req0,
  output logic             dma_req1,
  output logic             irq
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [2:0]  ctrl_reg;
  logic [31:0] count_reg;
  logic [31:0] pre_term_reg;
  logic [31:0] pre_cnt_reg;
  logic [31:0] match_reg [mct_pkg::N_MATCH];
  logic [11:0] match_ctrl_reg;
  logic [7:0]  act_reg;
  logic [1:0]  dma_en_reg;
  logic [5:0]  cap_ctrl_reg;
  logic [5:0]  status_reg;
  logic [5:0]  irq_en_reg;
  logic [3:0]  out_reg;
  logic [1:0]  dma_reg;
  logic        irq_reg;
  logic        wait_reg;
  logic        cin_prev_reg;
  logic [31:0] rdata_reg;
  logic [31:0] cap_val [mct_pkg::N_CAP];
  logic [1:0]  cap_ev;
  logic [31:0] rd_mux;

  function automatic logic [31:0] mct_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mct_drive(input logic cur, input logic [1:0] act);
    case (mct_pkg::mct_act_type'(act))
      mct_pkg::ACT_LOW:    return 1'b0;
      mct_pkg::ACT_HIGH:   return 1'b1;
      mct_pkg::ACT_TOGGLE: return ~cur;
      default:             return cur;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  wire logic        bus_req = avs_read | avs_write;
  wire logic        wr_go   = avs_write & ~wait_reg & clk_en;
  wire logic [31:0] wmerge0 = mct_merge(32'h0, avs_writedata, avs_byteenable);
  wire logic wr_ctrl   = wr_go & (avs_address == mct_pkg::OFF_CTRL);
  wire logic wr_count  = wr_go & (avs_address == mct_pkg::OFF_COUNT);
  wire logic wr_pre    = wr_go & (avs_address == mct_pkg::OFF_PRE_TERM);
  wire logic wr_mctrl  = wr_go & (avs_address == mct_pkg::OFF_MATCH_CTRL);
  wire logic wr_ectrl  = wr_go & (avs_address == mct_pkg::OFF_EXT_CTRL);
  wire logic wr_cctrl  = wr_go & (avs_address == mct_pkg::OFF_CAP_CTRL);
  wire logic wr_clear  = wr_go & (avs_address == mct_pkg::OFF_CLEAR);
  wire logic wr_irq_en = wr_go & (avs_address == mct_pkg::OFF_IRQ_EN);
  logic [3:0] wr_match;

  // ------------------------------------------------------------------
  // count source and prescaler
  // ------------------------------------------------------------------
  wire logic running  = ctrl_reg[mct_pkg::CTRL_RUN] & ~ctrl_reg[mct_pkg::CTRL_HOLD];
  wire logic ext_edge = count_in & ~cin_prev_reg;
  wire logic src_tick = ctrl_reg[mct_pkg::CTRL_EXT] ? ext_edge : 1'b1;
  wire logic src_go   = running & src_tick & clk_en;
  wire logic pre_done = src_go & (pre_cnt_reg == pre_term_reg);

  // ------------------------------------------------------------------
  // match compare
  // ------------------------------------------------------------------
  logic [3:0] hit;
  logic [3:0] mc_int;
  logic [3:0] mc_rst;
  logic [3:0] mc_stop;
  logic [3:0] out_next;

  for (genvar m = 0; m < mct_pkg::N_MATCH; m++) begin : g_match
    assign wr_match[m] = wr_go &
      (avs_address == mct_pkg::OFF_MATCH_BASE + 8'(m * 4));
    assign hit[m]      = pre_done & (count_reg == match_reg[m]);
    assign mc_int[m]   = match_ctrl_reg[m*mct_pkg::MC_STRIDE + mct_pkg::MC_INT];
    assign mc_rst[m]   = match_ctrl_reg[m*mct_pkg::MC_STRIDE + mct_pkg::MC_RST];
    assign mc_stop[m]  = match_ctrl_reg[m*mct_pkg::MC_STRIDE + mct_pkg::MC_STOP];
    assign out_next[m] = hit[m] ?
      mct_drive(out_reg[m], act_reg[m*mct_pkg::EC_ACT_W +: 2]) : out_reg[m];
  end

  wire logic any_rst  = |(hit & mc_rst);
  wire logic any_stop = |(hit & mc_stop);

  // ------------------------------------------------------------------
  // capture channels
  // ------------------------------------------------------------------
  wire logic [1:0] cap_pins = {timer0_capture_in1, timer0_capture_in0};
  logic [1:0] cap_int;

  for (genvar c = 0; c < mct_pkg::N_CAP; c++) begin : g_cap
    assign cap_int[c] = cap_ctrl_reg[c*mct_pkg::CC_STRIDE + mct_pkg::CC_INT];
    mct_capture #(
      .W (32)
    ) u_cap (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .cap_in    (cap_pins[c]),
      .rise_en   (cap_ctrl_reg[c*mct_pkg::CC_STRIDE + mct_pkg::CC_RISE]),
      .fall_en   (cap_ctrl_reg[c*mct_pkg::CC_STRIDE + mct_pkg::CC_FALL]),
      .count     (count_reg),
      .cap_value (cap_val[c]),
      .cap_event (cap_ev[c])
    );
  end

  // ------------------------------------------------------------------
  // next values
  // ------------------------------------------------------------------
  wire logic [5:0] events    = {cap_ev & cap_int, hit & mc_int};
  wire logic [5:0] clr_bits  = wr_clear ? wmerge0[5:0] : 6'h00;
  wire logic [5:0] status_next = (status_reg & ~clr_bits) | events;
  wire logic [31:0] count_wr = mct_merge(count_reg, avs_writedata, avs_byteenable);
  wire logic [31:0] mctrl_wr = mct_merge({20'h0, match_ctrl_reg}, avs_writedata, avs_byteenable);
  wire logic [31:0] count_next =
    wr_count                      ? count_wr :
    ctrl_reg[mct_pkg::CTRL_HOLD]  ? 32'h0 :
    !pre_done                     ? count_reg :
    any_rst                       ? 32'h0 :
    any_stop                      ? count_reg :
                                    count_reg + 32'h1;
  wire logic [31:0] pre_cnt_next =
    ctrl_reg[mct_pkg::CTRL_HOLD] ? 32'h0 :
    pre_done                     ? 32'h0 :
    src_go                       ? pre_cnt_reg + 32'h1 :
                                   pre_cnt_reg;
  wire logic [2:0] ctrl_stop = any_stop ?
    (ctrl_reg & ~3'(1 << mct_pkg::CTRL_RUN)) : ctrl_reg;
  wire logic [31:0] ext_word =
    {12'h000, out_reg, 6'h00, dma_en_reg, act_reg};

  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      mct_pkg::OFF_CTRL:       rd_mux = {29'h0, ctrl_reg};
      mct_pkg::OFF_COUNT:      rd_mux = count_reg;
      mct_pkg::OFF_PRE_TERM:   rd_mux = pre_term_reg;
      mct_pkg::OFF_PRE_CNT:    rd_mux = pre_cnt_reg;
      mct_pkg::OFF_MATCH_CTRL: rd_mux = {20'h0, match_ctrl_reg};
      mct_pkg::OFF_EXT_CTRL:   rd_mux = ext_word;
      mct_pkg::OFF_CAP_CTRL:   rd_mux = {26'h0, cap_ctrl_reg};
      mct_pkg::OFF_CAP0:       rd_mux = cap_val[0];
      mct_pkg::OFF_CAP1:       rd_mux = cap_val[1];
      mct_pkg::OFF_STATUS:     rd_mux = {26'h0, status_reg};
      mct_pkg::OFF_IRQ_EN:     rd_mux = {26'h0, irq_en_reg};
      default: begin
        if (avs_address[7:4] == mct_pkg::OFF_MATCH_BASE[7:4]) begin
          rd_mux = match_reg[avs_address[3:2]];
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // bus slave: one wait cycle, then a single ack cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wait_reg  <= 1'b1;
      rdata_reg <= mct_pkg::RST_WORD;
    end else if (clk_en) begin
      if (bus_req && wait_reg) begin
        wait_reg  <= 1'b0;
        rdata_reg <= rd_mux;
      end else begin
        wait_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // counter, prescaler and configuration
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_reg       <= mct_pkg::RST_CTRL;
      count_reg      <= mct_pkg::RST_WORD;
      pre_term_reg   <= mct_pkg::RST_WORD;
      pre_cnt_reg    <= mct_pkg::RST_WORD;
      match_ctrl_reg <= mct_pkg::RST_MATCH_CTRL;
      act_reg        <= mct_pkg::RST_ACT;
      dma_en_reg     <= mct_pkg::RST_DMA_EN;
      cap_ctrl_reg   <= mct_pkg::RST_CAP_CTRL;
      irq_en_reg     <= mct_pkg::RST_IRQ_EN;
      cin_prev_reg   <= 1'b0;
      for (int m = 0; m < mct_pkg::N_MATCH; m++) begin
        match_reg[m] <= mct_pkg::RST_WORD;
      end
    end else if (clk_en) begin
      cin_prev_reg <= count_in;
      count_reg    <= count_next;
      pre_cnt_reg  <= pre_cnt_next;
      ctrl_reg     <= wr_ctrl ? wmerge0[2:0] : ctrl_stop;
      if (wr_pre) pre_term_reg <= mct_merge(pre_term_reg, avs_writedata, avs_byteenable);
      if (wr_mctrl) match_ctrl_reg <= mctrl_wr[11:0];
      if (wr_ectrl) begin
        act_reg    <= wmerge0[7:0];
        dma_en_reg <= wmerge0[mct_pkg::EC_DMA_POS +: 2];
      end
      if (wr_cctrl) cap_ctrl_reg <= wmerge0[5:0];
      if (wr_irq_en) irq_en_reg <= wmerge0[5:0];
      for (int m = 0; m < mct_pkg::N_MATCH; m++) begin
        if (wr_match[m]) begin
          match_reg[m] <= mct_merge(match_reg[m], avs_writedata, avs_byteenable);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // events, outputs, interrupt
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_reg <= mct_pkg::RST_STATUS;
      out_reg    <= mct_pkg::RST_OUT;
      dma_reg    <= mct_pkg::RST_DMA_EN;
      irq_reg    <= 1'b0;
    end else if (clk_en) begin
      status_reg <= status_next;
      out_reg    <= out_next;
      dma_reg    <= hit[1:0] & dma_en_reg;
      irq_reg    <= |(status_next & irq_en_reg);
    end
  end

  assign avs_readdata      = rdata_reg;
  assign avs_waitrequest   = wait_reg;
  assign timer0_match_out0 = out_reg[0];
  assign timer0_match_out1 = out_reg[1];
  assign timer0_match_out2 = out_reg[2];
  assign timer0_match_out3 = out_reg[3];
  assign dma_req0          = dma_reg[0];
  assign dma_req1          = dma_reg[1];
  assign irq               = irq_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_EXT_SRC: assert property (
    clk_en && running && ctrl_reg[mct_pkg::CTRL_EXT] && !ext_edge && !wr_count
    |=> count_reg == $past(count_reg) && pre_cnt_reg == $past(pre_cnt_reg))
    else $error("counter moved without an external edge");
  AST_PRE_WRAP: assert property (
    pre_done && !ctrl_reg[mct_pkg::CTRL_HOLD] |=> pre_cnt_reg == 32'h0)
    else $error("prescaler did not restart at terminal value");
  AST_ADVANCE: assert property (
    pre_done && !any_rst && !any_stop && !wr_count && !ctrl_reg[mct_pkg::CTRL_HOLD]
    |=> count_reg == $past(count_reg) + 32'h1)
    else $error("count did not advance on prescale terminal");
  AST_CAP_FLAG: assert property (
    cap_ev[0] && cap_int[0] |=> status_reg[mct_pkg::ST_CAP_POS])
    else $error("capture flag not raised");
  AST_MATCH_FLAG: assert property (
    clk_en && (hit & mc_int) != 4'h0
    |=> (status_reg[3:0] & $past(hit & mc_int)) == $past(hit & mc_int))
    else $error("match flag not raised");
  AST_STOP: assert property (
    any_stop && !any_rst && !wr_ctrl && !wr_count
    |=> !ctrl_reg[mct_pkg::CTRL_RUN] && count_reg == $past(count_reg)
        ##1 count_reg == $past(count_reg))
    else $error("counter did not stop on match");
  AST_RESET: assert property (
    any_rst && !wr_count |=> count_reg == 32'h0)
    else $error("counter did not reset on match");
  AST_TOGGLE: assert property (
    hit[1] && act_reg[3:2] == 2'h3 |=> out_reg[1] != $past(out_reg[1]))
    else $error("match output did not toggle");
  AST_DMA: assert property (
    clk_en && dma_reg[1] |-> $past(hit[1]) && $past(dma_en_reg[1]))
    else $error("dma request without its match");
  AST_STICKY: assert property (
    clk_en && status_reg[0] && !clr_bits[0] |=> status_reg[0])
    else $error("flag lost without a clear");
  AST_ACK: assert property (
    clk_en && bus_req && wait_reg |=> !wait_reg ##1 wait_reg)
    else $error("bus ack not a single cycle");

  COV_RESET: cover property (any_rst);
  COV_STOP: cover property (any_stop);
  COV_DMA: cover property (dma_reg[1]);
  COV_IRQ: cover property (irq_reg && status_reg[mct_pkg::ST_CAP_POS]);
endmodule
